// [common/csf_pkg.sv]
// Constants and carrier types for the measurement frame builder
package csf_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned PERIOD_MS       = 10;
  localparam int unsigned PERIOD_CYC      = CLK_HZ / 1000 * PERIOD_MS;
  localparam int unsigned FRT_WINDOW_MS   = 500;
  localparam int unsigned FRT_WINDOW_CYC  = CLK_HZ / 1000 * FRT_WINDOW_MS;
  // Frame identity and layout
  localparam logic [10:0] FRAME_ID_DEF    = 11'h3C2;
  localparam int unsigned BYTE0_POS       = 56;
  localparam int unsigned PRI_POS         = 32;
  localparam int unsigned SEC_POS         = 16;
  localparam int unsigned RSV_POS         = 8;
  localparam int unsigned CRC_POS         = 0;
  localparam logic [7:0]  RSV_BYTE        = 8'h00;
  // Counter values and the absent-supply code
  localparam logic [3:0]  SEQ_RST         = 4'h0;
  localparam logic [3:0]  SEQ_LAST        = 4'hF;
  localparam logic [3:0]  SEQ_RESTART     = 4'h1;
  localparam logic [1:0]  SUPPLY_NA       = 2'h3;
  // Encodings
  localparam logic [23:0] PRI_ZERO        = 24'h80_0000;
  localparam logic [23:0] PRI_OVER        = 24'hFF_FFFF;
  localparam logic [15:0] SEC_ZERO        = 16'h8000;
  // Thresholds, primary in mA, secondary in A, supply in mV
  localparam logic signed [39:0] PRI_CLAMP_MA = 40'sd1550000;
  localparam logic signed [39:0] PRI_PEAK_MA  = 40'sd1700000;
  localparam logic signed [39:0] OVERCUR_MA   = 40'sd1600000;
  localparam logic signed [39:0] LOW_BAND_MA  = 40'sd220000;
  localparam logic signed [39:0] HIGH_BAND_MA = 40'sd1500000;
  localparam logic signed [39:0] LOW_GAP_MA   = 40'sd44000;
  localparam logic signed [39:0] PCT_DIV      = 40'sd5;
  localparam logic signed [39:0] MA_PER_A     = 40'sd1000;
  localparam logic signed [15:0] SEC_CLAMP_A  = 16'sd1550;
  localparam logic [15:0] SUPPLY_MIN_MV   = 16'd7800;
  localparam logic [15:0] SUPPLY_MAX_MV   = 16'd16200;
  // J1850 checksum
  localparam logic [7:0]  CRC_POLY        = 8'h1D;
  localparam logic [7:0]  CRC_INIT        = 8'hFF;
  localparam logic [7:0]  CRC_XOROUT      = 8'hFF;

  typedef struct packed {
    logic [10:0] id;
    logic [63:0] data;
  } csf_frame_s;

  typedef struct packed {
    logic signed [31:0] primary_ma;
    logic signed [15:0] secondary_a;
  } csf_sample_s;

  typedef struct packed {
    logic ref_err;
    logic conv_err;
    logic ripple_err;
  } csf_selfchk_s;
endpackage

// [logic/csf_frame_builder.sv]
// Periodic measurement frame builder with output buffer
`timescale 1ns/1ps
module csf_frame_builder #(
  parameter int unsigned PERIOD_CYCLES = csf_pkg::PERIOD_CYC
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Configuration
  input  wire logic [10:0]        frame_id,
  // Measurements, same clock domain
  input  wire csf_pkg::csf_sample_s  sample,
  input  wire csf_pkg::csf_selfchk_s selfchk,
  input  wire logic [15:0]        supply_mv,
  input  wire logic               supply_mv_valid,
  input  wire logic [1:0]         supply_status,
  // Frame stream to the CAN controller
  output logic                    out_valid,
  input  wire logic               out_ready,
  output csf_pkg::csf_frame_s     out_frame,
  // Status
  output logic                    started,
  output logic                    internal_fault,
  output logic                    channel_mismatch_flag
);
  import csf_pkg::*;

  function automatic logic signed [39:0] abs40(input logic signed [39:0] v);
    abs40 = (v < 0) ? -v : v;
  endfunction

  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 55; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    crc8 = c ^ CRC_XOROUT;
  endfunction

  // Period timer
  logic [31:0]  tick_cnt_q;
  logic         tick;
  logic         req_q;
  logic         push;
  logic         in_ready;
  logic [3:0]   seq_q;
  logic         started_q;

  assign tick = (tick_cnt_q == 32'(PERIOD_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  // Start-up gate; latched for good so a later dip never mutes the bus
  logic supply_ok;
  assign supply_ok = !supply_mv_valid ||
                     (supply_mv >= SUPPLY_MIN_MV &&
                      supply_mv <= SUPPLY_MAX_MV);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      started_q <= 1'b0;
    end else if (supply_ok) begin
      started_q <= 1'b1;
    end
  end

  // Request held while the buffer is full; a further tick while it is held adds no extra frame
  assign push = req_q && in_ready;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_q <= 1'b0;
    end else if (tick && started_q) begin
      req_q <= 1'b1;
    end else if (push) begin
      req_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_q <= SEQ_RST;
    end else if (push) begin
      seq_q <= (seq_q == SEQ_LAST) ? SEQ_RESTART
                                   : seq_q + 4'h1;
    end
  end

  // Sample evaluation, one pair per frame
  logic signed [39:0] pri_ma;
  logic signed [39:0] sec_ma;
  logic signed [39:0] pri_abs;
  logic signed [39:0] gap;
  logic signed [15:0] sec_cl;
  logic [23:0]        pri_code;
  logic [15:0]        sec_code;
  logic               fault_d;
  logic               mismatch_d;
  logic [1:0]         sup_d;
  logic [7:0]         byte0;
  logic [55:0]        body;
  csf_frame_s         frame_d;

  assign pri_ma  = 40'(sample.primary_ma);
  assign sec_ma  = 40'(sample.secondary_a) * MA_PER_A;
  assign pri_abs = abs40(pri_ma);
  assign gap     = abs40(pri_ma - sec_ma);

  always_comb begin
    if (pri_abs > PRI_PEAK_MA) begin
      pri_code = PRI_OVER;
    end else if (pri_ma > PRI_CLAMP_MA) begin
      pri_code = PRI_ZERO + 24'(PRI_CLAMP_MA);
    end else if (pri_ma < -PRI_CLAMP_MA) begin
      pri_code = PRI_ZERO - 24'(PRI_CLAMP_MA);
    end else begin
      pri_code = PRI_ZERO + 24'(pri_ma);
    end
  end

  always_comb begin
    if (sample.secondary_a > SEC_CLAMP_A) begin
      sec_cl = SEC_CLAMP_A;
    end else if (sample.secondary_a < -SEC_CLAMP_A) begin
      sec_cl = -SEC_CLAMP_A;
    end else begin
      sec_cl = sample.secondary_a;
    end
  end
  assign sec_code = SEC_ZERO + 16'(sec_cl);

  // Ripple is a live level, so its fault drops with the ripple
  assign fault_d = selfchk.ref_err || selfchk.conv_err ||
                   selfchk.ripple_err ||
                   (pri_abs > OVERCUR_MA);

  // Above 1500 A the channels are not compared; clamping makes it moot
  always_comb begin
    if (pri_abs <= LOW_BAND_MA) begin
      mismatch_d = (gap > LOW_GAP_MA);
    end else if (pri_abs <= HIGH_BAND_MA) begin
      mismatch_d = (gap * PCT_DIV > pri_abs);
    end else begin
      mismatch_d = 1'b0;
    end
  end

  assign sup_d  = supply_mv_valid ? supply_status : SUPPLY_NA;
  assign byte0  = {seq_q, sup_d, fault_d, mismatch_d};
  // Big-endian packing: byte 0 in the top bits goes out first
  assign body   = {byte0, pri_code, sec_code, RSV_BYTE};
  assign frame_d.id   = frame_id;
  assign frame_d.data = {body, crc8(body)};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      internal_fault        <= 1'b0;
      channel_mismatch_flag <= 1'b0;
    end else if (push) begin
      internal_fault        <= fault_d;
      channel_mismatch_flag <= mismatch_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      started <= 1'b0;
    end else begin
      started <= started_q;
    end
  end

  // Two-entry skid buffer: head drives the port, tail absorbs a stall
  csf_frame_s tail_q;
  logic       tail_v_q;
  logic       pop;

  assign pop      = out_valid && out_ready;
  assign in_ready = !tail_v_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_frame <= '0;
      tail_v_q  <= 1'b0;
      tail_q    <= '0;
    end else begin
      if (!out_valid || pop) begin
        if (tail_v_q) begin
          out_frame <= tail_q;
          out_valid <= 1'b1;
          tail_v_q  <= push;
          if (push) begin
            tail_q <= frame_d;
          end
        end else begin
          out_frame <= push ? frame_d : out_frame;
          out_valid <= push;
        end
      end else if (push) begin
        tail_q   <= frame_d;
        tail_v_q <= 1'b1;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_seq_inc;
    push && seq_q != SEQ_LAST |=> seq_q == $past(seq_q) + 4'h1;
  endproperty
  a_seq_inc: assert property (p_seq_inc)
    else $error("counter did not step by one");

  property p_seq_wrap;
    push && seq_q == SEQ_LAST |=> seq_q == SEQ_RESTART;
  endproperty
  a_seq_wrap: assert property (p_seq_wrap)
    else $error("counter did not reload with one");

  property p_no_early;
    !started_q |-> !push && !out_valid;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("frame emitted before start-up gate");

  property p_req_served;
    tick && started_q && !tail_v_q && !req_q |=> push;
  endproperty
  a_req_served: assert property (p_req_served)
    else $error("period request not turned into a frame");

  property p_layout;
    push |-> frame_d.data[63:60] == seq_q &&
             frame_d.data[7:0] == crc8(frame_d.data[63:8]) &&
             frame_d.data[15:8] == RSV_BYTE;
  endproperty
  a_layout: assert property (p_layout)
    else $error("byte layout or checksum wrong");

  property p_supply_na;
    push && !supply_mv_valid |-> frame_d.data[59:58] == SUPPLY_NA;
  endproperty
  a_supply_na: assert property (p_supply_na)
    else $error("absent supply not flagged as 11");

  property p_overcur;
    push && (pri_abs > OVERCUR_MA) |=> internal_fault;
  endproperty
  a_overcur: assert property (p_overcur)
    else $error("over-current did not set internal fault");

  property p_low_gap;
    push && pri_abs <= LOW_BAND_MA && gap > LOW_GAP_MA
      |=> channel_mismatch_flag;
  endproperty
  a_low_gap: assert property (p_low_gap)
    else $error("low-band mismatch missed");

  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_frame);
  endproperty
  a_hold: assert property (p_hold)
    else $error("frame changed under a stall");

  property p_peak;
    push && pri_abs > PRI_PEAK_MA |-> frame_d.data[55:32] == PRI_OVER;
  endproperty
  a_peak: assert property (p_peak)
    else $error("beyond-peak current not all ones");

  c_wrap:     cover property (push && seq_q == SEQ_LAST);
  c_mismatch: cover property (push && mismatch_d);
  c_full:     cover property (tail_v_q && req_q);
  c_fault:    cover property (push && selfchk.ripple_err);
endmodule

// [dv/csf_bms_sink.sv]
// Battery controller side model taking frames from the builder
`timescale 1ns/1ps
module csf_bms_sink (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Test control
  input  wire logic                stall,
  // Frame stream
  input  wire logic                valid,
  output logic                     ready,
  input  wire csf_pkg::csf_frame_s frame,
  // Captured frame
  output logic                     got,
  output csf_pkg::csf_frame_s      frm_q
);
  import csf_pkg::*;
  // Stall simply withholds ready, as a busy controller would
  assign ready = !stall;
  // Whole frame taken in one beat, byte 0 in the top bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      got   <= 1'b0;
      frm_q <= '0;
    end else begin
      got <= valid && ready;
      if (valid && ready) begin
        frm_q <= frame;
      end
    end
  end
endmodule

// [dv/csf_frame_builder_tb.sv]
// Self-checking bench for the measurement frame builder
`timescale 1ns/1ps
module csf_frame_builder_tb;
  import csf_pkg::*;
  localparam int P = 50;
  typedef struct packed {
    logic signed [31:0] p;
    logic signed [15:0] s;
    logic [2:0]         chk;
    logic               sv;
    logic [23:0]        ep;
    logic [15:0]        es;
    logic               f;
    logic               m;
  } csf_case_s;
  logic        clk, rst_b, stall, out_valid, out_ready, got, started;
  logic        internal_fault, channel_mismatch_flag, supply_mv_valid;
  logic [15:0] supply_mv;
  csf_sample_s  sample;
  csf_selfchk_s selfchk;
  csf_frame_s   out_frame, frm;
  csf_case_s    cs [14];
  int          miscompares, n_tests;
  logic [3:0]  seq;
  logic [63:0] d;
  logic [1:0]  sup_st, sup_e;
  csf_frame_builder #(.PERIOD_CYCLES(P)) i_dut (
    .clk(clk), .rst_b(rst_b), .frame_id(FRAME_ID_DEF), .sample(sample),
    .selfchk(selfchk), .supply_mv(supply_mv),
    .supply_mv_valid(supply_mv_valid), .supply_status(sup_st),
    .out_valid(out_valid), .out_ready(out_ready), .out_frame(out_frame),
    .started(started), .internal_fault(internal_fault),
    .channel_mismatch_flag(channel_mismatch_flag));
  csf_bms_sink i_sink (
    .clk(clk), .rst_b(rst_b), .stall(stall), .valid(out_valid),
    .ready(out_ready), .frame(out_frame), .got(got), .frm_q(frm));
  always #4 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [55:0] x);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 55; i >= 0; i--) begin
      c = (c[7] ^ x[i]) ? ({c[6:0], 1'b0} ^ 8'h1D) : {c[6:0], 1'b0};
    end
    return c ^ 8'hFF;
  endfunction
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Waits for one taken frame and checks its fixed fields
  task automatic get_frame();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (!got && n < 3 * P);
    chk("frame arrival", 32'h1, 32'(got));
    d = frm.data;
    chk("frame id", 32'(FRAME_ID_DEF), 32'(frm.id));
    chk("seq counter", 32'(seq), 32'(d[63:60]));
    chk("reserved byte", 32'h0, 32'(d[15:8]));
    chk("crc byte", 32'(crc8(d[63:8])), 32'(d[7:0]));
    seq = (seq == 4'hF) ? 4'h1 : seq + 4'h1;
  endtask
  initial begin
    clk = 0; rst_b = 0; stall = 0; supply_mv = 16'd5000;
    supply_mv_valid = 1; sample = '0; selfchk = '0; seq = 4'h0;
    sup_st = 2'h1;
    miscompares = 0; n_tests = 0;
    // Primary mA, secondary A, self-check, supply valid, expected codes
    cs[0]  = '{0, 0, 3'b000, 1, 24'h80_0000, 16'h8000, 0, 0};
    cs[1]  = '{1500000, 1500, 3'b000, 1, 24'h96_E360, 16'h85DC, 0, 0};
    cs[2]  = '{-1500000, -1500, 3'b000, 0, 24'h69_1CA0, 16'h7A24, 0, 0};
    cs[3]  = '{1600000, 1600, 3'b000, 1, 24'h97_A6B0, 16'h860E, 0, 0};
    cs[4]  = '{1650000, 1650, 3'b000, 1, 24'h97_A6B0, 16'h860E, 1, 0};
    cs[5]  = '{-1800000, -1800, 3'b000, 1, 24'hFF_FFFF, 16'h79F2, 1, 0};
    cs[6]  = '{100000, 145, 3'b000, 1, 24'h81_86A0, 16'h8091, 0, 1};
    cs[7]  = '{100000, 144, 3'b000, 1, 24'h81_86A0, 16'h8090, 0, 0};
    cs[8]  = '{220000, 265, 3'b000, 1, 24'h83_5B60, 16'h8109, 0, 1};
    cs[9]  = '{1000000, 799, 3'b000, 1, 24'h8F_4240, 16'h831F, 0, 1};
    cs[10] = '{1000000, 800, 3'b000, 1, 24'h8F_4240, 16'h8320, 0, 0};
    cs[11] = '{1, 0, 3'b100, 1, 24'h80_0001, 16'h8000, 1, 0};
    cs[12] = '{-1, -1, 3'b001, 1, 24'h7F_FFFF, 16'h7FFF, 1, 0};
    cs[13] = '{0, 0, 3'b000, 1, 24'h80_0000, 16'h8000, 0, 0};
    repeat (5) @(posedge clk);
    rst_b <= 1;
    // Supply out of range at start: no frame at all
    repeat (3 * P) @(posedge clk);
    supply_mv <= 16'd16300;
    repeat (3 * P) @(posedge clk);
    #1;
    chk("started low supply", 32'h0, 32'(started));
    chk("valid low supply", 32'h0, 32'(out_valid));
    @(posedge clk);
    supply_mv <= 16'd12000;
    for (int k = 0; k < 14; k++) begin
      @(posedge clk);
      sample <= '{cs[k].p, cs[k].s};
      selfchk <= cs[k].chk;
      supply_mv_valid <= cs[k].sv;
      sup_st <= 2'(k);
      sup_e = cs[k].sv ? 2'(k) : 2'h3;
      get_frame();
      get_frame();
      chk("supply bits", 32'(sup_e), 32'(d[59:58]));
      chk("fault bit", 32'(cs[k].f), 32'(d[57]));
      chk("mismatch bit", 32'(cs[k].m), 32'(d[56]));
      chk("fault out", 32'(cs[k].f), 32'(internal_fault));
      chk("mismatch", 32'(cs[k].m), 32'(channel_mismatch_flag));
      chk("primary", 32'(cs[k].ep), 32'(d[55:32]));
      chk("secondary", 32'(cs[k].es), 32'(d[31:16]));
    end
    // Receiver stalls: buffer fills, the fourth tick adds no frame, counter stays unbroken
    @(posedge clk);
    stall <= 1;
    repeat (4 * P) @(posedge clk);
    #1;
    chk("valid during stall", 32'h1, 32'(out_valid));
    @(posedge clk);
    stall <= 0;
    repeat (4) get_frame();
    chk("started high", 32'h1, 32'(started));
    // Second reset in mid-run: counter must begin again at zero
    @(posedge clk);
    rst_b <= 0;
    repeat (2) @(posedge clk);
    #1;
    chk("started in reset", 32'h0, 32'(started));
    chk("valid in reset", 32'h0, 32'(out_valid));
    @(posedge clk);
    rst_b <= 1;
    seq = 4'h0;
    get_frame();
    chk("started again", 32'h1, 32'(started));
    final_report();
  end
  // Watchdog well beyond the expected run of about 2,000 cycles
  initial begin
    #(8 * 40000);
    miscompares++;
    final_report();
  end
endmodule
